// [lim_pkg.sv]
// Constants and types for the laser interlock mode controller
package lim_pkg;
  // Timing
  localparam int CLK_HZ         = 20_000_000;
  localparam int OPEN_DELAY_S   = 10;
  localparam int OPEN_DELAY_CYC = OPEN_DELAY_S * CLK_HZ;
  localparam int TRAVEL_MS      = 500;
  localparam int TRAVEL_CYC     = TRAVEL_MS * (CLK_HZ / 1000);
  localparam int DEB_US         = 100;
  localparam int DEB_CYC        = DEB_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W          = 28;
  localparam int DEB_W          = 11;
  localparam int NSH            = 2;
  // Pin vector positions
  localparam int P_KEY   = 0;
  localparam int P_EOFF0 = 1;
  localparam int P_EOFF1 = 2;
  localparam int P_DOOR0 = 3;
  localparam int P_DOOR1 = 4;
  localparam int P_COVER = 5;
  localparam int P_PWR   = 6;
  localparam int P_IN0   = 7;
  localparam int P_OUT0  = 9;
  localparam int P_BADGE = 11;
  localparam int P_PRES  = 12;
  localparam int NPIN    = 13;
  // Fault latch bits
  localparam int F_EOFF  = 0;
  localparam int F_PWR   = 1;
  localparam int F_DOOR  = 2;
  localparam int F_COVER = 3;
  localparam int F_INC0  = 4;
  localparam int NFLT    = 6;
  localparam logic [5:0] FLT_OFF = 6'h3B;
  localparam logic [5:0] FLT_PSU = 6'h0B;
  // Register byte addresses
  localparam logic [5:0] A_CMD  = 6'h00;
  localparam logic [5:0] A_STAT = 6'h04;
  localparam logic [5:0] A_FLT  = 6'h08;
  // Command register fields
  localparam int C_MODE   = 0;
  localparam int C_GO     = 3;
  localparam int C_OPEN0  = 4;
  localparam int C_CLOSE0 = 6;
  localparam int C_RST    = 8;
  localparam int C_REMOTE = 9;
  localparam int C_PWD    = 10;
  // Status register fields
  localparam int S_MODE = 0;
  localparam int S_OPEN = 3;
  localparam int S_PSU  = 5;
  localparam int S_WARN = 7;
  localparam int S_INC  = 8;
  localparam int S_ERR  = 9;
  localparam int S_IN   = 10;
  localparam int S_OUT  = 12;
  localparam int S_KEY  = 14;
  typedef enum logic [2:0] {
    M_OFF = 3'h0, M_ENCL = 3'h1, M_NORM = 3'h2, M_MAINT = 3'h3,
    M_JOB = 3'h4, M_PARAM = 3'h5, M_HARM = 3'h6
  } lim_mode_t;
  typedef enum logic [1:0] {
    SH_CLOSED = 2'h0, SH_WARN = 2'h1, SH_OPEN = 2'h2
  } lim_shut_t;
endpackage

// [lim_ctrl.sv]
// Laser interlock and operating mode controller with Avalon-MM registers
// Notes on behaviour
// - Emergency off closes shutters, drops supply permits
// - Emergency off also forces laser-off mode
// - Warn during ten second delay before opening
// - Flag both, neither, or missing inserted sensor
// - Inconsistency warns and drops that laser's permit
// - Inserted sensor shown as monitored status output
// - Interlock faults latch until explicit reset
// - Lost interlock line or power trips everything
// - Open door (normal mode and above) or cover contact (enclosed mode) means fault
// - Fault reset needs valid authorization
// - Door fault closes shutters; emergencies drop supplies
// - Laser-off mode: no permits, shutters closed
// - High-hazard modes enable supplies and shutters
// - Key turned on starts in laser-off
// - Enclosed mode needs closed enclosure cover
// - Normal, maintenance, job-analysis modes are distinct
// - Parametric and harmonics modes as extra values
// - Enclosure cover fault disables enclosed lasers
// - Remote commands refused while personnel present unless the password bit is set; closes always taken
// - Local requests other than closing accepted only with approved badge
// - Two redundant transport shutters on path one
// - Key removal trips everything, sets laser-off
// - Mode request refused when interlocks unmet
`timescale 1ns/1ps
module lim_ctrl #(
  parameter int unsigned OPEN_DELAY_CYC_P = lim_pkg::OPEN_DELAY_CYC,
  parameter int unsigned TRAVEL_CYC_P     = lim_pkg::TRAVEL_CYC
) (
  // Clock, reset, enable
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    ce,
  // Avalon-MM slave
  input  wire logic [5:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  // Panel and interlock pins
  input  wire logic                    keyOn,
  input  wire logic [1:0]              eoffClosed,
  input  wire logic [1:0]              doorClosed,
  input  wire logic                    coverClosed,
  input  wire logic                    intlkPowerOk,
  input  wire logic [lim_pkg::NSH-1:0] shutInSens,
  input  wire logic [lim_pkg::NSH-1:0] shutOutSens,
  input  wire logic                    badgeOk,
  input  wire logic                    personnelPresent,
  // Permits and indicators
  output logic [lim_pkg::NSH-1:0]      shutterOpen,
  output logic [1:0]                   transportOpen,
  output logic [lim_pkg::NSH-1:0]      psuPermit,
  output logic                         openWarn,
  output logic                         inconsAlarm,
  output logic                         modeErr,
  output lim_pkg::lim_mode_t           mode,
  output logic [lim_pkg::NSH-1:0]      shutInStatus
);
  import lim_pkg::*;

  logic [NPIN-1:0]  pinRaw;
  logic [NPIN-1:0]  sync1;
  logic [NPIN-1:0]  sync2;
  logic [NPIN-1:0]  deb;
  logic [31:0]      cmd;
  logic             cmdWr;
  logic             cmdOk;
  logic             auth;
  logic             rstAcc;
  logic             keyOk;
  logic             doorsOk;
  logic             class4;
  logic             travelDone;
  lim_mode_t        reqMode;
  logic [NFLT-1:0]  cause;

  assign pinRaw = {personnelPresent, badgeOk, shutOutSens, shutInSens, intlkPowerOk,
                   coverClosed, doorClosed, eoffClosed, keyOn};

  // Two-stage synchroniser on every pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (ce) begin
      sync1 <= pinRaw;
      sync2 <= sync1;
    end
  end

  // Debounce: a level is taken once stable for DEB_CYC cycles
  for (genvar g = 0; g < NPIN; g++) begin : g_deb
    logic [DEB_W-1:0] cnt_reg;
    logic [DEB_W-1:0] cnt_next;
    logic             val_reg;
    logic             val_next;
    always_comb begin
      cnt_next = cnt_reg;
      val_next = val_reg;
      if (sync2[g] == val_reg) begin
        cnt_next = '0;
      end else if (cnt_reg == DEB_W'(DEB_CYC - 1)) begin
        val_next = sync2[g];
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        cnt_reg <= '0;
        val_reg <= 1'b0;
      end else if (ce) begin
        cnt_reg <= cnt_next;
        val_reg <= val_next;
      end
    end
    assign deb[g] = val_reg;
  end

  // Bus slave state
  logic        wait_reg;
  logic        wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] stat;

  // Control state
  lim_mode_t         mode_reg;
  lim_mode_t         mode_next;
  logic [NFLT-1:0]   fault_reg;
  logic [NFLT-1:0]   fault_next;
  lim_shut_t         shState_reg [NSH];
  lim_shut_t         shState_next [NSH];
  logic [CNT_W-1:0]  dly_reg [NSH];
  logic [CNT_W-1:0]  dly_next [NSH];
  logic [CNT_W-1:0]  travel_reg;
  logic [CNT_W-1:0]  travel_next;
  logic              modeErr_reg;
  logic              modeErr_next;
  logic [NSH-1:0]    open_reg;
  logic [NSH-1:0]    open_next;
  logic [1:0]        transport_reg;
  logic [1:0]        transport_next;
  logic [NSH-1:0]    psu_reg;
  logic [NSH-1:0]    psu_next;
  logic              warn_reg;
  logic              warn_next;
  logic              inc_reg;
  logic              inc_next;
  logic [NSH-1:0]    inStat_reg;
  logic              forceOff;
  logic              reqOk;
  logic              hazard;
  logic              shAllow;
  logic              psuOk;

  assign cmd     = avs_writedata;
  assign cmdWr   = ce && avs_write && !wait_reg && (avs_address == A_CMD);
  // Remote origin needs clear area or password; local needs a badge
  assign auth    = cmd[C_REMOTE] ? (!deb[P_PRES] || cmd[C_PWD]) : deb[P_BADGE];
  assign cmdOk   = cmdWr && auth;
  assign rstAcc  = cmdOk && cmd[C_RST];
  assign reqMode = lim_mode_t'(cmd[C_MODE +: 3]);
  assign keyOk   = deb[P_KEY];
  assign doorsOk = deb[P_DOOR0] && deb[P_DOOR1];
  assign class4  = mode_reg >= M_NORM;
  assign travelDone = travel_reg == '0;

  // Fault causes; an open or unplugged contact reads as fault
  always_comb begin
    cause          = '0;
    cause[F_EOFF]  = !(deb[P_EOFF0] && deb[P_EOFF1]);
    cause[F_PWR]   = !deb[P_PWR];
    cause[F_DOOR]  = class4 && !doorsOk;
    cause[F_COVER] = (mode_reg == M_ENCL) && !deb[P_COVER];
    for (int i = 0; i < NSH; i++) begin
      cause[F_INC0 + i] = travelDone && ((deb[P_IN0 + i] == deb[P_OUT0 + i]) ||
                          (!deb[P_IN0 + i] && !open_reg[i]));
    end
  end

  always_comb begin
    // A new cause wins over a reset in the same cycle
    fault_next = (rstAcc ? '0 : fault_reg) | cause;
    forceOff   = !keyOk || (|(fault_next & FLT_OFF));
    mode_next  = mode_reg;
    modeErr_next = modeErr_reg;
    unique case (reqMode)
      M_OFF:   reqOk = 1'b1;
      M_ENCL:  reqOk = keyOk && deb[P_COVER] && (fault_next == '0);
      M_NORM, M_MAINT, M_JOB, M_PARAM, M_HARM: begin
        reqOk = keyOk && doorsOk && (fault_next == '0);
      end
      default: reqOk = 1'b0;
    endcase
    if (forceOff) begin
      mode_next = M_OFF;
    end else if (cmdOk && cmd[C_GO]) begin
      if (reqOk) begin
        mode_next = reqMode;
        modeErr_next = 1'b0;
      end else begin
        modeErr_next = 1'b1;
      end
    end
    hazard  = mode_next != M_OFF;
    shAllow = hazard && (fault_next == '0);
    psuOk   = hazard && !(|(fault_next & FLT_PSU)) &&
              !(fault_next[F_DOOR] && (mode_next == M_MAINT || mode_next == M_JOB));
    warn_next = 1'b0;
    for (int i = 0; i < NSH; i++) begin
      shState_next[i] = shState_reg[i];
      dly_next[i]     = dly_reg[i];
      unique case (shState_reg[i])
        SH_CLOSED: begin
          if (cmdOk && cmd[C_OPEN0 + i] && shAllow) begin
            shState_next[i] = SH_WARN;
            dly_next[i]     = '0;
          end
        end
        SH_WARN: begin
          if (dly_reg[i] == CNT_W'(OPEN_DELAY_CYC_P - 1)) begin
            shState_next[i] = SH_OPEN;
          end else begin
            dly_next[i] = dly_reg[i] + 1'b1;
          end
        end
        SH_OPEN: begin
        end
        default: shState_next[i] = SH_CLOSED;
      endcase
      // Closing is always allowed and needs no badge
      if (!shAllow || (cmdWr && cmd[C_CLOSE0 + i])) begin
        shState_next[i] = SH_CLOSED;
      end
      open_next[i] = shState_next[i] == SH_OPEN;
      psu_next[i]  = psuOk && !fault_next[F_INC0 + i];
      warn_next    = warn_next || (shState_next[i] == SH_WARN);
    end
    transport_next = {2{open_next[NSH-1]}};
    inc_next = |fault_next[F_INC0 +: NSH];
    // Sensors are ignored while a shutter is still moving
    if (open_next != open_reg) begin
      travel_next = CNT_W'(TRAVEL_CYC_P - 1);
    end else if (travelDone) begin
      travel_next = '0;
    end else begin
      travel_next = travel_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg      <= M_OFF;
      fault_reg     <= '0;
      travel_reg    <= '0;
      modeErr_reg   <= 1'b0;
      open_reg      <= '0;
      transport_reg <= '0;
      psu_reg       <= '0;
      warn_reg      <= 1'b0;
      inc_reg       <= 1'b0;
      inStat_reg    <= '0;
      for (int i = 0; i < NSH; i++) begin
        shState_reg[i] <= SH_CLOSED;
        dly_reg[i]     <= '0;
      end
    end else if (ce) begin
      mode_reg      <= mode_next;
      fault_reg     <= fault_next;
      travel_reg    <= travel_next;
      modeErr_reg   <= modeErr_next;
      open_reg      <= open_next;
      transport_reg <= transport_next;
      psu_reg       <= psu_next;
      warn_reg      <= warn_next;
      inc_reg       <= inc_next;
      inStat_reg    <= deb[P_IN0 +: NSH];
      for (int i = 0; i < NSH; i++) begin
        shState_reg[i] <= shState_next[i];
        dly_reg[i]     <= dly_next[i];
      end
    end
  end

  // Bus: one wait cycle, then the answer
  always_comb begin
    stat = '0;
    stat[S_MODE +: 3]   = mode_reg;
    stat[S_OPEN +: NSH] = open_reg;
    stat[S_PSU +: NSH]  = psu_reg;
    stat[S_WARN]        = warn_reg;
    stat[S_INC]         = inc_reg;
    stat[S_ERR]         = modeErr_reg;
    stat[S_IN +: NSH]   = deb[P_IN0 +: NSH];
    stat[S_OUT +: NSH]  = deb[P_OUT0 +: NSH];
    stat[S_KEY]         = keyOk;
    wait_next  = !((avs_read || avs_write) && wait_reg);
    rdata_next = rdata_reg;
    if (avs_read && wait_reg) begin
      unique case (avs_address)
        A_STAT:  rdata_next = stat;
        A_FLT:   rdata_next = {{(32 - NFLT){1'b0}}, fault_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_reg  <= 1'b1;
      rdata_reg <= '0;
    end else if (ce) begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign shutterOpen     = open_reg;
  assign transportOpen   = transport_reg;
  assign psuPermit       = psu_reg;
  assign openWarn        = warn_reg;
  assign inconsAlarm     = inc_reg;
  assign modeErr         = modeErr_reg;
  assign mode            = mode_reg;
  assign shutInStatus    = inStat_reg;

  // Checks
  sequence s_trip;
    ce && cause[F_EOFF];
  endsequence
  sequence s_allOff;
    psuPermit == '0 && shutterOpen == '0 && transportOpen == '0;
  endsequence
  property p_eoff_off;
    @(posedge clk) disable iff (!rstn) s_trip |=> s_allOff;
  endproperty
  a_eoff_off: assert property (p_eoff_off) else $error("eoff left a permit on");
  property p_eoff_mode;
    @(posedge clk) disable iff (!rstn)
      s_trip |=> (mode == M_OFF) ##1 (!ce || mode == M_OFF);
  endproperty
  a_eoff_mode: assert property (p_eoff_mode) else $error("eoff kept hazard mode");
  property p_warn;
    @(posedge clk) disable iff (!rstn) $rose(shutterOpen[0]) |-> $past(openWarn);
  endproperty
  a_warn: assert property (p_warn) else $error("shutter opened without warning");
  sequence s_incons;
    ce && travelDone && deb[P_IN0] && deb[P_OUT0];
  endsequence
  property p_incons;
    @(posedge clk) disable iff (!rstn)
      s_incons |=> inconsAlarm && psuPermit[0] == 1'b0 && mode == M_OFF;
  endproperty
  a_incons: assert property (p_incons) else $error("inconsistency not acted on");
  property p_key;
    @(posedge clk) disable iff (!rstn) ce && !keyOk |=> s_allOff and (mode == M_OFF);
  endproperty
  a_key: assert property (p_key) else $error("key removal did not trip");
  property p_latch;
    @(posedge clk) disable iff (!rstn) ce && fault_reg != '0 && !rstAcc |=> shutterOpen == '0;
  endproperty
  a_latch: assert property (p_latch) else $error("shutter open with latched fault");
  property p_unauth;
    @(posedge clk) disable iff (!rstn)
      cmdWr && cmd[C_RST] && !auth && fault_reg != '0 |=> fault_reg != '0;
  endproperty
  a_unauth: assert property (p_unauth) else $error("unauthorized reset cleared fault");
  property p_reject;
    @(posedge clk) disable iff (!rstn)
      cmdOk && cmd[C_GO] && reqMode >= M_NORM && !doorsOk && !forceOff
      |=> mode == $past(mode) && modeErr;
  endproperty
  a_reject: assert property (p_reject) else $error("mode entered with door open");
  property p_transport;
    @(posedge clk) disable iff (!rstn) transportOpen[0] == transportOpen[1];
  endproperty
  a_transport: assert property (p_transport) else $error("transport pair differs");
  property p_remote;
    @(posedge clk) disable iff (!rstn)
      cmdWr && cmd[C_GO] && cmd[C_REMOTE] && !cmd[C_PWD] && deb[P_PRES] && !forceOff
      |=> mode == $past(mode);
  endproperty
  a_remote: assert property (p_remote) else $error("remote request taken");
  property p_bus;
    @(posedge clk) disable iff (!rstn) ce && avs_read && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("read not answered");
endmodule

// [lim_shutter_model.sv]
// Behavioural model of two safety shutters with inserted and withdrawn sensors
`timescale 1ns/1ps
module lim_shutter_model #(
  parameter int FAST = 8,
  parameter int SLOW = 600
) (
  // Clock and commands
  input  wire logic       clk,
  input  wire logic [1:0] openCmd,
  // Fault injection and pace
  input  wire logic [1:0] stuck,
  input  wire logic       slow,
  // Position sensors
  output logic [1:0]      inSens,
  output logic [1:0]      outSens
);
  logic [1:0] posOut = 2'b00;
  int         cnt [2] = '{0, 0};
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (openCmd[i] === posOut[i])
        cnt[i] <= 0;
      else if (cnt[i] >= (slow ? SLOW : FAST))
        posOut[i] <= openCmd[i];
      else
        cnt[i] <= cnt[i] + 1;
    end
  end
  // In transit neither sensor is lit; a stuck shutter lights both
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      inSens[i]  = stuck[i] | (!posOut[i] & (openCmd[i] === posOut[i]));
      outSens[i] = stuck[i] | (posOut[i] & (openCmd[i] === posOut[i]));
    end
  end
endmodule

// [test_laser_interlock_mode_controller.sv]
// Self-checking testbench for the laser interlock mode controller
`timescale 1ns/1ps
module test_laser_interlock_mode_controller;
  import lim_pkg::*;
  localparam int OPEN_P = 20;
  localparam int TRAV_P = 3000;
  localparam int SETTLE = 2800;
  logic        clk, rstn, ce, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        keyOn, coverClosed, intlkPowerOk, badgeOk, personnelPresent, slow;
  logic        openWarn, inconsAlarm, modeErr;
  logic [1:0]  eoffClosed, doorClosed, shutInSens, shutOutSens, stuck;
  logic [1:0]  shutterOpen, transportOpen, psuPermit, shutInStatus;
  logic [2:0]  code;
  lim_mode_t   mode, cur;
  int          num_errors, tests_run;
  int unsigned seed;

  lim_ctrl #(.OPEN_DELAY_CYC_P(OPEN_P), .TRAVEL_CYC_P(TRAV_P)) lim_ctrl_inst (
    .clk, .rstn, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .keyOn, .eoffClosed, .doorClosed, .coverClosed,
    .intlkPowerOk, .shutInSens, .shutOutSens, .badgeOk, .personnelPresent,
    .shutterOpen, .transportOpen, .psuPermit, .openWarn, .inconsAlarm, .modeErr,
    .mode, .shutInStatus);
  lim_shutter_model lim_shutter_model_inst (
    .clk, .openCmd(shutterOpen), .stuck, .slow, .inSens(shutInSens),
    .outSens(shutOutSens));

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkm(input lim_mode_t got, input lim_mode_t exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: mode %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 100) begin
      num_errors++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask
  task automatic cmd(input logic [31:0] d);
    bus(1'b1, A_CMD, d);
    cyc(2);
  endtask
  task automatic rdreg(input logic [5:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic clr;
    cmd(32'h0000_0100);
    rdreg(A_FLT);
    chk(rd, 32'h0000_0000);
  endtask
  function automatic logic [1:0] psuExp(lim_mode_t m);
    return (m != M_OFF) ? 2'b11 : 2'b00;
  endfunction
  // Expected status word with no fault, no warning and shutters settled
  function automatic logic [31:0] statExp(lim_mode_t m, logic [1:0] op);
    return {17'h0_0000, 1'b1, op, ~op, 3'b000, psuExp(m), op, m};
  endfunction
  task automatic setMode(input lim_mode_t m);
    cmd(32'h0000_0008 | m);
    chkm(mode, m);
    rdreg(A_STAT);
    chk(rd, statExp(m, 2'b00));
  endtask
  task automatic setPin(input int k, input logic v);
    case (k)
      0: eoffClosed[0] <= v;
      1: eoffClosed[1] <= v;
      2: intlkPowerOk <= v;
      3: keyOn <= v;
      default: coverClosed <= v;
    endcase
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #4_500_000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0; ce = 1'b1; avs_address = 6'h00; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0000_0000; keyOn = 1'b1; eoffClosed = 2'b11; doorClosed = 2'b11;
    coverClosed = 1'b1; intlkPowerOk = 1'b1; badgeOk = 1'b0; personnelPresent = 1'b1;
    stuck = 2'b00; slow = 1'b0; num_errors = 0; tests_run = 0;
    seed = $urandom(90);
    cyc(3);
    chk({avs_waitrequest, psuPermit, shutterOpen, openWarn, inconsAlarm, modeErr}, 8'h80);
    chkm(mode, M_OFF);
    rstn <= 1'b1;
    cyc(TRAV_P + 200);
    rdreg(A_FLT);
    chk(rd[1:0], 2'h3);
    cmd(32'h0000_0100);
    cmd(32'h0000_0300);
    rdreg(A_FLT);
    chk(rd[1:0], 2'h3);
    cmd(32'h0000_0700);
    rdreg(A_FLT);
    chk(rd, 32'h0000_0000);
    // Hazard request with no badge, then remote with people present
    cmd(32'h0000_000A);
    chkm(mode, M_OFF);
    chk(modeErr, 1'h0);
    cmd(32'h0000_020A);
    chkm(mode, M_OFF);
    badgeOk <= 1'b1;
    personnelPresent <= 1'b0;
    cyc(SETTLE);
    // Every mode code in turn, then random codes
    cur = M_OFF;
    for (int i = 0; i < 12; i++) begin
      code = (i < 8) ? 3'(i) : 3'($urandom % 8);
      cmd(32'h0000_0008 | code);
      if (code != 3'h7) cur = lim_mode_t'(code);
      chkm(mode, cur);
      chk(modeErr, code == 3'h7);
      chk(psuPermit, psuExp(cur));
    end
    setMode(M_NORM);
    slow <= 1'($urandom);
    cmd(32'h0000_0030);
    chk({openWarn, shutterOpen}, 3'h4);
    ce <= 1'b0;
    cyc(40);
    chk({openWarn, shutterOpen}, 3'h4);
    ce <= 1'b1;
    cyc(OPEN_P - 6);
    chk({openWarn, shutterOpen}, 3'h4);
    cyc(8);
    chk({openWarn, shutterOpen, transportOpen}, 5'h0F);
    cyc(SETTLE);
    chk(shutInStatus, 2'b00);
    rdreg(A_STAT);
    chk(rd, statExp(M_NORM, 2'b11));
    doorClosed <= 2'b10;
    cyc(SETTLE);
    chk({shutterOpen, transportOpen, psuPermit}, 6'h03);
    chkm(mode, M_NORM);
    cmd(32'h0000_000C);
    chk(modeErr, 1'h1);
    chkm(mode, M_NORM);
    doorClosed <= 2'b11;
    cyc(SETTLE);
    cmd(32'h0000_0010);
    chk({openWarn, shutterOpen}, 3'h0);
    clr();
    // Close request withdraws an open shutter and its transport pair
    cmd(32'h0000_0020);
    cyc(OPEN_P + 10);
    chk({shutterOpen, transportOpen}, 4'hB);
    cmd(32'h0000_0080);
    chk({openWarn, shutterOpen, transportOpen}, 5'h00);
    setMode(M_MAINT);
    doorClosed <= 2'b01;
    cyc(SETTLE);
    chk(psuPermit, 2'b00);
    chkm(mode, M_MAINT);
    doorClosed <= 2'b11;
    cyc(SETTLE);
    clr();
    // Trip causes: both emergency-off buttons, power, key, enclosure cover
    for (int k = 0; k < 5; k++) begin
      setMode((k == 4) ? M_ENCL : M_NORM);
      if (k < 4) begin
        slow <= 1'($urandom);
        cmd(32'h0000_0020);
        cyc(OPEN_P + 10);
        chk(shutterOpen, 2'b10);
      end
      setPin(k, 1'b0);
      cyc(SETTLE);
      chk({shutterOpen, transportOpen, psuPermit}, 6'h00);
      chkm(mode, M_OFF);
      setPin(k, 1'b1);
      cyc(SETTLE);
      chkm(mode, M_OFF);
      clr();
    end
    setMode(M_NORM);
    stuck <= 2'b01;
    cyc(SETTLE);
    chk({inconsAlarm, psuPermit}, 3'h4);
    chkm(mode, M_OFF);
    rdreg(A_FLT);
    chk(rd, 32'h0000_0010);
    stuck <= 2'b00;
    cyc(SETTLE);
    clr();
    bus(1'b1, A_STAT, 32'hFFFF_FFFF);
    rdreg(A_STAT);
    chk(rd, statExp(M_OFF, 2'b00));
    rdreg(6'h0C);
    chk(rd, 32'h0000_0000);
    rdreg(A_CMD);
    chk(rd, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
